// >>> include/slope_codec_pkg.sv
/*
  Package for the slope delta codec logic: widths, reset patterns and
  arithmetic constants for the digital integrator and syllabic filter.
  Assumes a single 250 MHz reference clock and a bit-rate enable divider.
*/
package slope_codec_pkg;
  localparam int LEVEL_W = 16;
  localparam int SYL_W = 16;
  localparam int HIST_MAX = 4;
  localparam logic [3:0] HIST_RESET = 4'h5;
  localparam logic [15:0] LEVEL_MID = 16'h8000;
  localparam logic [15:0] STEP_MIN = 16'h0010;
  localparam logic [15:0] SYL_CHARGE = 16'h0400;
  localparam int SYL_DECAY_SHIFT = 5;
  localparam int STEP_SHIFT = 4;
  localparam int LEAK_SHIFT = 8;
  localparam int CLK_HZ = 250_000_000;
  localparam int BIT_RATE_HZ = 64_000;
  localparam int BIT_DIV = CLK_HZ / BIT_RATE_HZ;
  localparam int DUTY_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 1;
endpackage

// >>> src/bit_fifo.sv
/*
  Small synchronous FIFO of flip-flops with valid and ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk, // Clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] in_data, // Write data
  input wire logic in_valid, // Write request
  output logic in_ready, // Room available
  output logic [WIDTH-1:0] out_data, // Head of queue
  output logic out_valid, // Queue not empty
  input wire logic out_ready // Reader takes head
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
endmodule

// >>> src/slope_delta_codec_logic.sv
/*
  Clocked decision and coincidence logic of a slope delta voice codec with a
  digital integrator and syllabic filter. Assumes the analog comparison arrives
  as an asynchronous pin, and that decode bits arrive through the input FIFO.
*/
// Function
// R1 - Integrator level rises when emitted bit is high, falls when low
// R2 - Encode emits high while input exceeds feedback, low otherwise
// R3 - Step size is the integrator change over exactly one bit period
// R4 - Remote receiver integrates the bit stream with a matching integrator
// R5 - History of three or four bits; coincidence when all ones or zeros
// R6 - Each coincidence charges the syllabic filter, enlarging the step
// R7 - Encode/decode select chooses comparator or external bits for history
// R8 - In decode the far side supplies one received bit per codec clock
// R9 - Exactly one bit processed per bit-rate enable period
// R10 - Coincidence output duty cycle follows the syllabic filter level
// R11 - Each decision appears on the serial output bit
// R12 - System supplies a bit clock of at least 9600 Hz, ideally 64 kHz
// R13 - Three-bit history up to 16 kHz, four-bit from 32 kHz
// R14 - Idle input settles to an alternating one-zero output pattern
// R15 - New bit shifts into history; coincidence judged from updated contents
// R16 - Reset loads the history with alternating bits, so no coincidence
`timescale 1ns/1ps
module slope_delta_codec_logic #(
  parameter int BIT_DIV = slope_codec_pkg::BIT_DIV,
  parameter int LEVEL_W = slope_codec_pkg::LEVEL_W
) (
  input wire logic ref_clk, // 250 MHz clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic encode_sel, // 1 encode, 0 decode (static)
  input wire logic four_bit_sel, // 1 four-bit history, 0 three-bit
  input wire logic input_above_pin, // Comparator: analog input above feedback
  input wire logic rx_bit, // Received serial bit for decode
  input wire logic rx_valid, // Received bit offered
  output logic rx_ready, // Room for a received bit
  output logic serial_bit_out, // Serial decision bit
  output logic bit_strobe, // One-cycle pulse per processed bit
  output logic coincidence_out, // Duty-cycle coincidence output
  output logic [LEVEL_W-1:0] local_integrator_level, // Integrator feedback level
  output logic [LEVEL_W-1:0] reconstructed_level, // Level in decode mode
  output logic [LEVEL_W-1:0] step_size // Step of the last bit period
);
  // ==================================================
  // Bit-rate enable and pin synchroniser
  localparam int DIV_W = $clog2(BIT_DIV + 1);
  logic [DIV_W-1:0] div_cnt, next_div_cnt;
  logic bit_en, next_bit_en;
  logic [2:0] cmp_sync;
  logic cmp_level, next_cmp_level;

  always_comb begin
    next_bit_en = 1'b0;
    next_div_cnt = div_cnt + 1'b1;
    if (div_cnt == DIV_W'(BIT_DIV - 1)) begin
      next_div_cnt = '0;
      next_bit_en = 1'b1; // R9
    end
    // Only a stable reading of the last two stages changes the level
    next_cmp_level = (cmp_sync[2] == cmp_sync[1]) ? cmp_sync[2] : cmp_level;
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      div_cnt <= '0;
      bit_en <= 1'b0;
      cmp_sync <= 3'h0;
      cmp_level <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      bit_en <= next_bit_en;
      cmp_sync <= {cmp_sync[1:0], input_above_pin};
      cmp_level <= next_cmp_level;
    end
  end

  // ==================================================
  // Received bit queue
  logic fifo_bit, fifo_valid, fifo_take, rx_ready_c;

  bit_fifo #(
    .WIDTH(slope_codec_pkg::FIFO_W),
    .DEPTH(slope_codec_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .in_data(rx_bit),
    .in_valid(rx_valid),
    .in_ready(rx_ready_c),
    .out_data(fifo_bit),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );

  // Decode takes one queued bit per bit period; underrun repeats no bit
  assign fifo_take = bit_en && !encode_sel; // R8

  // ==================================================
  // Decision, history and coincidence
  logic [3:0] hist, next_hist;
  logic next_serial, next_strobe, coinc, next_coinc;
  logic new_bit;

  always_comb begin
    // Underrun in decode falls back to alternating so the level idles
    if (encode_sel) begin
      new_bit = cmp_level; // R2 R7
    end else if (fifo_valid) begin
      new_bit = fifo_bit; // R7
    end else begin
      new_bit = ~hist[0]; // R14
    end
    next_hist = hist;
    next_serial = serial_bit_out;
    next_strobe = 1'b0;
    if (bit_en) begin
      next_hist = {hist[2:0], new_bit}; // R15
      next_serial = new_bit; // R11
      next_strobe = 1'b1;
    end
    if (four_bit_sel) begin
      next_coinc = (next_hist == 4'hf) || (next_hist == 4'h0); // R5 R13
    end else begin
      next_coinc = (next_hist[2:0] == 3'h7) || (next_hist[2:0] == 3'h0); // R5 R13
    end
    next_coinc = next_coinc && bit_en; // R15
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hist <= slope_codec_pkg::HIST_RESET; // R16
      serial_bit_out <= 1'b0;
      bit_strobe <= 1'b0;
      coinc <= 1'b0;
    end else begin
      hist <= next_hist;
      serial_bit_out <= next_serial;
      bit_strobe <= next_strobe;
      coinc <= next_coinc;
    end
  end

  // ==================================================
  // Syllabic filter, step size and integrator
  logic [15:0] syl, next_syl;
  logic [LEVEL_W-1:0] level, next_level, next_step, step_amt;
  logic [LEVEL_W:0] sum;

  always_comb begin
    next_syl = syl;
    if (bit_en) begin
      // Leak each bit, charge on coincidence: more coincidence, more charge
      next_syl = syl - (syl >> slope_codec_pkg::SYL_DECAY_SHIFT);
      if (next_coinc) begin
        next_syl = (next_syl > ~slope_codec_pkg::SYL_CHARGE) ? 16'hffff
                   : next_syl + slope_codec_pkg::SYL_CHARGE; // R6
      end
    end
    step_amt = LEVEL_W'(slope_codec_pkg::STEP_MIN) + LEVEL_W'(syl >> slope_codec_pkg::STEP_SHIFT); // R6
    next_level = level;
    next_step = step_size;
    sum = '0;
    if (bit_en) begin
      if (new_bit) begin
        sum = {1'b0, level} + {1'b0, step_amt};
        next_level = sum[LEVEL_W] ? {LEVEL_W{1'b1}} : sum[LEVEL_W-1:0]; // R1
      end else begin
        next_level = (level < step_amt) ? '0 : level - step_amt; // R1
      end
      next_step = (next_level > level) ? next_level - level : level - next_level; // R3
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      syl <= 16'h0000;
      level <= slope_codec_pkg::LEVEL_MID;
      step_size <= 16'h0000;
    end else begin
      syl <= next_syl;
      level <= next_level;
      step_size <= next_step;
    end
  end

  // ==================================================
  // Coincidence duty output: PWM compare against the filter level
  logic [slope_codec_pkg::DUTY_W-1:0] pwm_cnt;
  logic next_coinc_out;
  logic [LEVEL_W-1:0] next_local, next_recon;

  always_comb begin
    next_coinc_out = (pwm_cnt < syl[15 -: slope_codec_pkg::DUTY_W]); // R10
    next_local = encode_sel ? level : local_integrator_level;
    next_recon = encode_sel ? reconstructed_level : level; // R4
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pwm_cnt <= '0;
      coincidence_out <= 1'b0;
      local_integrator_level <= slope_codec_pkg::LEVEL_MID;
      reconstructed_level <= slope_codec_pkg::LEVEL_MID;
      rx_ready <= 1'b0;
    end else begin
      pwm_cnt <= pwm_cnt + 1'b1;
      coincidence_out <= next_coinc_out;
      local_integrator_level <= next_local;
      reconstructed_level <= next_recon;
      rx_ready <= rx_ready_c;
    end
  end

  // ==================================================
  // Assertions
  property p_bit_period; // R9
    @(posedge ref_clk) disable iff (!reset_n)
      bit_strobe |=> !bit_strobe;
  endproperty
  a_bit_period: assert property (p_bit_period) else $error("Bit strobe repeated"); // R9

  property p_serial_hold; // R11
    @(posedge ref_clk) disable iff (!reset_n)
      !bit_strobe |-> $stable(serial_bit_out);
  endproperty
  a_serial_hold: assert property (p_serial_hold) else $error("Serial bit changed off strobe"); // R11

  property p_up; // R1
    @(posedge ref_clk) disable iff (!reset_n)
      bit_en && new_bit && level < 16'hf000 |=> level > $past(level);
  endproperty
  a_up: assert property (p_up) else $error("Integrator did not rise"); // R1

  property p_down; // R1
    @(posedge ref_clk) disable iff (!reset_n)
      bit_en && !new_bit && level > 16'h1000 |=> level < $past(level);
  endproperty
  a_down: assert property (p_down) else $error("Integrator did not fall"); // R1

  property p_coinc; // R5
    @(posedge ref_clk) disable iff (!reset_n)
      bit_en && four_bit_sel && next_hist == 4'hf |=> coinc;
  endproperty
  a_coinc: assert property (p_coinc) else $error("Coincidence missed"); // R5

  property p_no_false; // R15
    @(posedge ref_clk) disable iff (!reset_n)
      coinc |-> (hist[2:0] == 3'h7 || hist[2:0] == 3'h0);
  endproperty
  a_no_false: assert property (p_no_false) else $error("False coincidence"); // R15

  property p_charge; // R6
    @(posedge ref_clk) disable iff (!reset_n)
      next_coinc && syl < 16'h8000 |=> syl > $past(syl);
  endproperty
  a_charge: assert property (p_charge) else $error("Filter not charged"); // R6

  property p_encode; // R2
    @(posedge ref_clk) disable iff (!reset_n)
      bit_en && encode_sel |=> serial_bit_out == $past(cmp_level);
  endproperty
  a_encode: assert property (p_encode) else $error("Encode bit mismatch"); // R2

  property p_step_size; // R3
    @(posedge ref_clk) disable iff (!reset_n)
      bit_strobe |-> step_size == ((level >= $past(level)) ? level - $past(level) : $past(level) - level);
  endproperty
  a_step_size: assert property (p_step_size) else $error("Step size not one-period change"); // R3

  property p_coinc_three; // R5
    @(posedge ref_clk) disable iff (!reset_n)
      bit_en && !four_bit_sel && next_hist[2:0] == 3'h0 |=> coinc;
  endproperty
  a_coinc_three: assert property (p_coinc_three) else $error("Three-bit coincidence missed"); // R5

  property p_duty_zero; // R10
    @(posedge ref_clk) disable iff (!reset_n)
      syl[15 -: slope_codec_pkg::DUTY_W] == '0 |=> !coincidence_out;
  endproperty
  a_duty_zero: assert property (p_duty_zero) else $error("Duty output high with empty filter"); // R10

  property p_decode_frozen; // R7
    @(posedge ref_clk) disable iff (!reset_n)
      !encode_sel |=> $stable(local_integrator_level);
  endproperty
  a_decode_frozen: assert property (p_decode_frozen) else $error("Encode level moved in decode"); // R7
endmodule

// >>> test/delta_receiver_model.sv
/*
  Far-end demodulator model: integrates the received serial bit stream.
  Assumes its gain follows the sender's step output, as a matched receiver
  tracking the same syllabic state would.
*/
`timescale 1ns/1ps
module delta_receiver_model (
  input wire logic ref_clk, // Clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic serial_bit, // Received bit
  input wire logic bit_strobe, // Bit valid pulse
  input wire logic [15:0] step, // Step of the matching integrator
  output logic [15:0] level // Reconstructed level
);
  // ==========================================
  // Integrator
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      level <= slope_codec_pkg::LEVEL_MID;
    end else if (bit_strobe) begin
      level <= serial_bit ? level + step : level - step;
    end
  end
endmodule

// >>> test/slope_delta_codec_logic_tb.sv
/*
  Bench for the slope codec logic: idle loop, slope runs, decode queue.
  Assumes the package, FIFO and codec sources are compiled before it.
*/
`timescale 1ns/1ps
module slope_delta_codec_logic_tb;
  localparam int DIV = 8;
  logic ref_clk, reset_n, encode_sel, four_bit_sel, input_above_pin, rx_bit, rx_valid;
  logic rx_ready, serial_bit_out, bit_strobe, coincidence_out;
  logic [15:0] local_integrator_level, reconstructed_level, step_size, rx_level, analog;
  int mismatches, tests_run, gap;
  slope_delta_codec_logic #(.BIT_DIV(DIV), .LEVEL_W(16)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .encode_sel(encode_sel), .four_bit_sel(four_bit_sel), .input_above_pin(input_above_pin),
    .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_ready(rx_ready), .serial_bit_out(serial_bit_out),
    .bit_strobe(bit_strobe), .coincidence_out(coincidence_out), .step_size(step_size),
    .local_integrator_level(local_integrator_level), .reconstructed_level(reconstructed_level));
  delta_receiver_model u_far (.ref_clk(ref_clk), .reset_n(reset_n), .serial_bit(serial_bit_out),
    .bit_strobe(bit_strobe), .step(step_size), .level(rx_level));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Comparator stand-in closes the loop, so idle really alternates
  always @(negedge ref_clk) input_above_pin <= analog > local_integrator_level;
  // ==========================================
  // Shared tasks
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_bit();
    gap = 0;
    do begin
      @(negedge ref_clk);
      gap++;
    end while (bit_strobe !== 1'b1 && gap < 40);
    check("strobe seen", 16'h0001, 16'(bit_strobe));
    // Levels and the far model settle one cycle after the strobe
    @(negedge ref_clk);
    gap++;
  endtask
  task automatic count_duty(output int ones);
    ones = 0;
    repeat (256) begin
      @(negedge ref_clk);
      ones += int'(coincidence_out);
    end
  endtask
  task automatic do_reset(logic enc, logic four);
    reset_n = 1'b0;
    encode_sel = enc;
    four_bit_sel = four;
    repeat (4) @(negedge ref_clk);
    check("reset level", slope_codec_pkg::LEVEL_MID, local_integrator_level);
    check("reset step", 16'h0000, step_size);
    check("reset outputs", 16'h0000, {13'h0000, serial_bit_out, coincidence_out, rx_ready});
    reset_n = 1'b1;
  endtask
  // ==========================================
  // Scenarios
  task automatic test_idle();
    logic prev;
    int ones;
    do_reset(1'b1, 1'b1);
    repeat (4) wait_bit();
    prev = serial_bit_out;
    repeat (8) begin
      wait_bit();
      check("idle bit", 16'(!prev), 16'(serial_bit_out));
      check("idle step", slope_codec_pkg::STEP_MIN, step_size);
      prev = serial_bit_out;
    end
    count_duty(ones);
    check("idle duty", 16'h0000, 16'(ones));
  endtask
  task automatic run_level(logic [15:0] target, logic bit_exp);
    logic [15:0] last;
    int ones;
    analog = target;
    repeat (2) wait_bit();
    last = local_integrator_level;
    repeat (6) begin
      wait_bit();
      check("bit spacing", 16'(DIV), 16'(gap));
      check("encoded bit", 16'(bit_exp), 16'(serial_bit_out));
      check("far level", local_integrator_level, rx_level);
      check("level move", bit_exp ? last + step_size : last - step_size, local_integrator_level);
      check("step", bit_exp ? local_integrator_level - last : last - local_integrator_level, step_size);
      last = local_integrator_level;
    end
    check("step grown", 16'h0001, 16'(step_size > slope_codec_pkg::STEP_MIN));
    count_duty(ones);
    check("slope duty", 16'h0001, 16'(ones > 0));
  endtask
  task automatic test_decode(logic four);
    logic [15:0] pat;
    logic [15:0] last;
    logic prev;
    int i;
    pat = 16'h1B2D;
    last = slope_codec_pkg::LEVEL_MID;
    do_reset(1'b0, four);
    i = 0;
    while (rx_ready !== 1'b1 && i < 20) begin
      @(negedge ref_clk);
      i++;
    end
    fork
      begin
        for (int k = 15; k >= 0; k--) begin
          check("room", 16'h0001, 16'(rx_ready));
          rx_bit = pat[k];
          rx_valid = 1'b1;
          @(negedge ref_clk);
        end
        rx_valid = 1'b0;
      end
      for (int j = 15; j >= 0; j--) begin
        wait_bit();
        check("decoded bit", 16'(pat[j]), 16'(serial_bit_out));
        check("encode level frozen", slope_codec_pkg::LEVEL_MID, local_integrator_level);
        check("far level", reconstructed_level, rx_level);
        check("level move", pat[j] ? last + step_size : last - step_size, reconstructed_level);
        if (j == 12) begin
          check("history length", 16'(!four), 16'(step_size > slope_codec_pkg::STEP_MIN));
        end
        last = reconstructed_level;
      end
    join
    // Queue empty: the design fills in with the complement of the last bit
    prev = serial_bit_out;
    wait_bit();
    check("underrun bit", 16'(!prev), 16'(serial_bit_out));
  endtask
  // ==========================================
  // Run control
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #40000;
    mismatches++;
    give_verdict();
  end
  initial begin
    mismatches = 0;
    tests_run = 0;
    reset_n = 1'b0;
    encode_sel = 1'b1;
    four_bit_sel = 1'b1;
    rx_bit = 1'b0;
    rx_valid = 1'b0;
    analog = 16'h8000;
    test_idle();
    run_level(16'hFFFF, 1'b1);
    run_level(16'h0000, 1'b0);
    test_decode(1'b1);
    test_decode(1'b0);
    give_verdict();
  end
endmodule
